// [hw/rps_supervisor.sv]
// two-port serial link configuration and communications error supervisor
module rps_supervisor #(
  parameter int TICK_CYCLES = rps_pkg::TICK_CYCLES,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic drive_running,
  input wire logic run_from_link,
  input wire logic freq_from_link,
  input wire logic alarm_reset,
  input wire logic option_comm_alarm,
  input wire logic option_bus_alarm,
  input wire logic unit_link_alarm,
  input wire logic [1:0] comm_error_data_clear,
  input wire rps_pkg::rps_cfg_t port1_cfg,
  input wire rps_pkg::rps_cfg_t port2_cfg,
  input wire rps_pkg::rps_req_t port1_req,
  input wire rps_pkg::rps_req_t port2_req,
  input wire logic port1_resp_valid,
  input wire logic [7:0] port1_resp_data,
  output logic port1_resp_ready,
  input wire logic port2_resp_valid,
  input wire logic [7:0] port2_resp_data,
  output logic port2_resp_ready,
  output logic port1_tx_valid,
  output logic [7:0] port1_tx_data,
  input wire logic port1_tx_ready,
  output logic port2_tx_valid,
  output logic [7:0] port2_tx_data,
  input wire logic port2_tx_ready,
  output rps_pkg::rps_fmt_t port1_fmt,
  output rps_pkg::rps_fmt_t port2_fmt,
  output logic port1_execute,
  output logic port2_execute,
  output logic port1_comm_alarm,
  output logic port2_comm_alarm,
  output logic alarm_stop,
  output logic clear_freq_cmds,
  output logic clear_run_bits
);

  if (TICK_CYCLES < 2 || FIFO_DEPTH < 2) begin : g_chk
    $error("rps_supervisor: tick and fifo depth must be 2 or more");
  end

  // ==========================================================
  // helper functions

  // legal station address
  function automatic logic addr_legal(input logic [5:0] proto, input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (proto == rps_pkg::PROTO_MODBUS) begin
      ok = a >= rps_pkg::ADDR_MIN && a <= rps_pkg::ADDR_MAX_MODBUS;
    end else if (proto == rps_pkg::PROTO_GENERAL) begin
      ok = a >= rps_pkg::ADDR_MIN && a <= rps_pkg::ADDR_MAX_GENERAL;
    end else if (proto == rps_pkg::PROTO_BACNET) begin
      ok = a >= rps_pkg::ADDR_MIN && a <= rps_pkg::ADDR_MAX_BACNET;
    end else begin
      ok = a >= rps_pkg::ADDR_MIN;
    end
    return ok;
  endfunction : addr_legal

  // broadcast address match
  function automatic logic is_bcast(input logic [5:0] proto, input logic [7:0] a);
    logic b;
    b = 1'b0;
    if (proto == rps_pkg::PROTO_MODBUS) begin
      b = a == rps_pkg::BCAST_MODBUS;
    end else if (proto == rps_pkg::PROTO_GENERAL) begin
      b = a == rps_pkg::BCAST_GENERAL;
    end else if (proto == rps_pkg::PROTO_BACNET) begin
      b = a == rps_pkg::BCAST_BACNET;
    end
    return b;
  endfunction : is_bcast

  // bit divider; unknown codes give 9600
  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    int rate;
    rate = rps_pkg::BAUD_2;
    case (sel)
      3'h0: rate = rps_pkg::BAUD_0;
      3'h1: rate = rps_pkg::BAUD_1;
      3'h3: rate = rps_pkg::BAUD_3;
      3'h4: rate = rps_pkg::BAUD_4;
      default: rate = rps_pkg::BAUD_2;
    endcase
    return 16'(rps_pkg::CLK_HZ / rate);
  endfunction : baud_div

  // ==========================================================
  // base tick
  logic [31:0] tick_cnt_r;
  logic tick_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (ce) begin
      tick_r <= tick_cnt_r == 32'(TICK_CYCLES - 1);
      if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
        tick_cnt_r <= '0;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // per-port arrays
  rps_pkg::rps_cfg_t cfg [2];
  rps_pkg::rps_req_t req [2];
  logic resp_valid [2];
  logic [7:0] resp_data [2];
  logic resp_ready [2];
  logic tx_ready [2];
  logic tx_valid [2];
  logic [7:0] tx_data [2];
  rps_pkg::rps_fmt_t fmt [2];
  logic execute [2];
  logic alarm [2];
  logic qualify;

  assign cfg[0] = port1_cfg;
  assign cfg[1] = port2_cfg;
  assign req[0] = port1_req;
  assign req[1] = port2_req;
  assign resp_valid[0] = port1_resp_valid;
  assign resp_valid[1] = port2_resp_valid;
  assign resp_data[0] = port1_resp_data;
  assign resp_data[1] = port2_resp_data;
  assign tx_ready[0] = port1_tx_ready;
  assign tx_ready[1] = port2_tx_ready;
  assign port1_resp_ready = resp_ready[0];
  assign port2_resp_ready = resp_ready[1];
  assign port1_tx_valid = tx_valid[0];
  assign port2_tx_valid = tx_valid[1];
  assign port1_tx_data = tx_data[0];
  assign port2_tx_data = tx_data[1];
  assign port1_fmt = fmt[0];
  assign port2_fmt = fmt[1];
  assign port1_execute = execute[0];
  assign port2_execute = execute[1];
  assign port1_comm_alarm = alarm[0];
  assign port2_comm_alarm = alarm[1];

  // errors count only while link-run
  assign qualify = drive_running & run_from_link & freq_from_link; // R4

  // ==========================================================
  // identical logic for each port, except the pump link accepted on port 2 only
  for (genvar g = 0; g < 2; g++) begin : g_port // R22
    rps_pkg::rps_cfg_t c;
    rps_pkg::rps_req_t r;
    logic proto_ok;
    logic station_ok;
    logic bcast;
    logic hit;
    logic frame_bad;
    logic good_access;
    logic answer;
    logic nr_hit;
    logic err_ev;
    logic [12:0] nr_limit;
    logic [12:0] et_limit;
    logic [12:0] nr_cnt_r;
    logic nr_fired_r;
    logic [12:0] et_cnt_r;
    logic [12:0] et_nxt;
    rps_pkg::rps_err_state_t st_r;
    rps_pkg::rps_err_state_t st_nxt;
    logic alarm_r;
    logic exec_r;
    logic [6:0] ri_cnt_r;
    logic pend_r;
    logic gate_r;
    logic drop_r;
    logic f_valid;
    logic [7:0] f_data;
    logic f_ready;
    logic tx_valid_r;
    logic [7:0] tx_data_r;
    rps_pkg::rps_fmt_t fmt_r;

    assign c = cfg[g];
    assign r = req[g];

    // request qualification
    assign proto_ok = c.protocol_select == rps_pkg::PROTO_MODBUS
                    || c.protocol_select == rps_pkg::PROTO_LOADER
                    || c.protocol_select == rps_pkg::PROTO_GENERAL
                    || c.protocol_select == rps_pkg::PROTO_N2
                    || c.protocol_select == rps_pkg::PROTO_BACNET
                    || (c.protocol_select == rps_pkg::PROTO_PUMP && g == 1); // R17
    assign station_ok = addr_legal(c.protocol_select, c.station_address); // R1
    assign bcast = is_bcast(c.protocol_select, r.addr); // R1
    assign hit = r.addr == c.station_address || bcast;
    assign frame_bad = r.addr_err | r.parity_err | r.framing_err | r.xfer_err;
    assign good_access = r.done & hit & ~frame_bad & station_ok & proto_ok;
    assign answer = good_access & ~bcast; // R2 R20

    // no-response watchdog
    assign nr_limit = 13'(c.no_response_time * 13'(rps_pkg::TICKS_PER_SECOND));
    assign nr_hit = c.no_response_time != '0 && !nr_fired_r && nr_cnt_r >= nr_limit; // R15
    assign err_ev = (r.done & frame_bad) | nr_hit; // R3

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        nr_cnt_r <= '0;
        nr_fired_r <= 1'b0;
      end else if (ce) begin
        if (good_access || c.no_response_time == '0) begin
          nr_cnt_r <= '0;
          nr_fired_r <= 1'b0;
        end else begin
          if (tick_r && nr_cnt_r < nr_limit) begin
            nr_cnt_r <= nr_cnt_r + 13'h0001;
          end
          if (nr_hit) begin
            nr_fired_r <= 1'b1;
          end
        end
      end
    end

    // error action state machine
    assign et_limit = 13'(c.error_timer * 13'(rps_pkg::TICKS_PER_ERR_UNIT)); // R9
    always_comb begin
      st_nxt = st_r;
      et_nxt = et_cnt_r;
      case (st_r)
        rps_pkg::ST_IDLE: begin
          et_nxt = '0;
          if (err_ev && qualify) begin // R4
            if (c.error_action == rps_pkg::ACT_ALARM_NOW) begin
              st_nxt = rps_pkg::ST_ALARM; // R5
            end else if (c.error_action != rps_pkg::ACT_CONTINUE) begin
              st_nxt = rps_pkg::ST_GRACE; // R6 R7
            end
          end
        end
        rps_pkg::ST_GRACE: begin
          if (!qualify) begin
            st_nxt = rps_pkg::ST_IDLE;
          end else if (c.error_action == rps_pkg::ACT_RETRY && good_access) begin
            st_nxt = rps_pkg::ST_IDLE; // R7
          end else if (et_cnt_r >= et_limit) begin
            st_nxt = rps_pkg::ST_ALARM; // R6 R7 R10
          end else if (tick_r) begin
            et_nxt = et_cnt_r + 13'h0001;
          end
        end
        rps_pkg::ST_ALARM: begin
          if (alarm_reset) begin
            st_nxt = rps_pkg::ST_IDLE;
          end
        end
        default: st_nxt = rps_pkg::ST_IDLE;
      endcase
      // action 3 never alarms; under action 0 a fresh error beats a same-cycle reset
      if (st_r == rps_pkg::ST_ALARM && alarm_reset && err_ev && qualify
          && c.error_action == rps_pkg::ACT_ALARM_NOW) begin
        st_nxt = rps_pkg::ST_ALARM; // R5
      end
    end // R8

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        st_r <= rps_pkg::ST_IDLE;
        et_cnt_r <= '0;
        alarm_r <= 1'b0;
      end else if (ce) begin
        st_r <= st_nxt;
        et_cnt_r <= et_nxt;
        alarm_r <= st_nxt == rps_pkg::ST_ALARM;
      end
    end

    // execute strobe, broadcasts included
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        exec_r <= 1'b0;
      end else if (ce) begin
        exec_r <= good_access; // R20
      end
    end

    // response interval gate or drop
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        ri_cnt_r <= '0;
        pend_r <= 1'b0;
        gate_r <= 1'b0;
        drop_r <= 1'b0;
      end else if (ce) begin
        if (r.done && (hit || frame_bad)) begin
          ri_cnt_r <= '0;
          pend_r <= answer;
          gate_r <= 1'b0;
          drop_r <= ~answer; // R2 R20
        end else if (pend_r) begin
          if (ri_cnt_r >= c.response_interval) begin
            pend_r <= 1'b0;
            gate_r <= 1'b1; // R16
          end else if (tick_r) begin
            ri_cnt_r <= ri_cnt_r + 7'h01;
          end
        end
      end
    end

    // response byte buffer
    rps_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
    ) u_fifo (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ce(ce),
      .in_valid(resp_valid[g]),
      .in_data(resp_data[g]),
      .in_ready(resp_ready[g]),
      .out_valid(f_valid),
      .out_data(f_data),
      .out_ready(f_ready)
    );

    // drain when the gate opens, discard when dropped
    assign f_ready = drop_r | (gate_r & (~tx_valid_r | tx_ready[g]));

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        tx_valid_r <= 1'b0;
        tx_data_r <= '0;
      end else if (ce) begin
        if (f_valid && gate_r && !drop_r && (!tx_valid_r || tx_ready[g])) begin
          tx_valid_r <= 1'b1;
          tx_data_r <= f_data;
        end else if (tx_ready[g]) begin
          tx_valid_r <= 1'b0;
        end
      end
    end

    // character format
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        fmt_r <= '0;
      end else if (ce) begin
        fmt_r.baud_div <= baud_div(c.baud_select); // R11
        fmt_r.data8 <= ~c.char_length | (c.protocol_select == rps_pkg::PROTO_LOADER); // R12 R21
        if (c.protocol_select == rps_pkg::PROTO_LOADER) begin
          fmt_r.parity_en <= 1'b1; // R14
          fmt_r.parity_odd <= 1'b0;
          fmt_r.two_stop <= 1'b0;
        end else begin
          fmt_r.parity_en <= c.parity_select == rps_pkg::PAR_EVEN
                           || c.parity_select == rps_pkg::PAR_ODD;
          fmt_r.parity_odd <= c.parity_select == rps_pkg::PAR_ODD;
          if (c.protocol_select == rps_pkg::PROTO_MODBUS) begin
            fmt_r.two_stop <= c.parity_select == rps_pkg::PAR_NONE_2STOP; // R13
          end else begin
            fmt_r.two_stop <= ~c.stop_select; // R14
          end
        end
      end
    end

    assign tx_valid[g] = tx_valid_r;
    assign tx_data[g] = tx_data_r;
    assign fmt[g] = fmt_r;
    assign execute[g] = exec_r;
    assign alarm[g] = alarm_r;
  end

  // ==========================================================
  // alarm stop and clearing
  logic [4:0] alarm_src;
  logic [4:0] alarm_prev_r;
  logic clear_trig;

  assign alarm_src = {alarm[0], alarm[1], option_comm_alarm, option_bus_alarm, unit_link_alarm};
  assign clear_trig = |(alarm_src & ~alarm_prev_r); // R18

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      alarm_prev_r <= '0;
      alarm_stop <= 1'b0;
      clear_freq_cmds <= 1'b0;
      clear_run_bits <= 1'b0;
    end else if (ce) begin
      alarm_prev_r <= alarm_src;
      alarm_stop <= alarm[0] | alarm[1]; // R5 R6 R7
      clear_freq_cmds <= clear_trig & comm_error_data_clear[0]; // R19
      clear_run_bits <= clear_trig & comm_error_data_clear[1]; // R19
    end
  end

endmodule : rps_supervisor

// [hw/rps_pkg.sv]
// shared constants and types of the port supervisor
// Function
// R1: station range: Modbus 1-247 bcast 0, BACnet 1-127 bcast 255
// R2: illegal station for the protocol: never respond
// R3: address, parity, framing, transfer faults and silence are errors
// R4: errors act only while running with run and frequency from link
// R5: action 0 alarms and stops at once
// R6: action 1 runs out the timer, then alarm stop
// R7: action 2 waits the timer; recovery continues, else alarm stop
// R8: action 3 keeps running after errors
// R9: error timer spans 0.0 to 60.0 s
// R10: error when no expected access within the timer
// R11: baud 0..4: 2400, 4800, 9600, 19200, 38400 bps; for 2400 the 16-bit divider 83333 wraps to 17797
// R12: length 0 is 8 bits, 1 is 7; loader always 8
// R13: Modbus stop from parity: 0 none/2, 1 even/1, 2 odd/1, 3 none/1
// R14: loader even parity, one stop; else stop 0 two, 1 one
// R15: silence time 0 off, 1-60 s starts the error action
// R16: answer delayed 0.00-1.00 s after request end
// R17: protocols 0,1,2,3,5; 50 pump link on port 2 only
// R18: clear fires only on a comm alarm of any source
// R19: clear 0 keeps, 1 frequency/aux, 2 run bits, 3 both
// R20: broadcasts execute without response
// R21: start 0, data LSB first, optional parity, stop 1
// R22: two identical independent ports
package rps_pkg;

  // ==========================================================
  // clock and base tick
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_ERR_UNIT = 10;   // error timer unit 0.1 s
  localparam int TICKS_PER_SECOND = 100;    // no-response unit 1 s
  localparam int TICKS_PER_RESP_UNIT = 1;   // response interval unit 0.01 s

  // ==========================================================
  // setting limits
  localparam logic [9:0] ERR_TIMER_MAX = 10'h258;   // 60.0 s
  localparam logic [5:0] NO_RESP_MAX = 6'h3c;       // 60 s
  localparam logic [6:0] RESP_INT_MAX = 7'h64;      // 1.00 s

  // ==========================================================
  // station address ranges and broadcast codes
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX_MODBUS = 8'hf7;
  localparam logic [7:0] ADDR_MAX_GENERAL = 8'h1f;
  localparam logic [7:0] ADDR_MAX_BACNET = 8'h7f;
  localparam logic [7:0] BCAST_MODBUS = 8'h00;
  localparam logic [7:0] BCAST_GENERAL = 8'h63;
  localparam logic [7:0] BCAST_BACNET = 8'hff;

  // ==========================================================
  // protocol codes
  localparam logic [5:0] PROTO_MODBUS = 6'h00;
  localparam logic [5:0] PROTO_LOADER = 6'h01;
  localparam logic [5:0] PROTO_GENERAL = 6'h02;
  localparam logic [5:0] PROTO_N2 = 6'h03;
  localparam logic [5:0] PROTO_BACNET = 6'h05;
  localparam logic [5:0] PROTO_PUMP = 6'h32;

  // ==========================================================
  // error actions, parity codes, baud rates
  localparam logic [1:0] ACT_ALARM_NOW = 2'h0;
  localparam logic [1:0] ACT_RUN_THEN_ALARM = 2'h1;
  localparam logic [1:0] ACT_RETRY = 2'h2;
  localparam logic [1:0] ACT_CONTINUE = 2'h3;
  localparam logic [1:0] PAR_NONE_2STOP = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam int BAUD_0 = 2400;
  localparam int BAUD_1 = 4800;
  localparam int BAUD_2 = 9600;
  localparam int BAUD_3 = 19200;
  localparam int BAUD_4 = 38400;

  // ==========================================================
  // types
  typedef struct packed {
    logic [7:0] station_address;
    logic [1:0] error_action;
    logic [9:0] error_timer;       // 0.1 s units
    logic [2:0] baud_select;
    logic char_length;
    logic [1:0] parity_select;
    logic stop_select;
    logic [5:0] no_response_time;  // 1 s units
    logic [6:0] response_interval; // 0.01 s units
    logic [5:0] protocol_select;
  } rps_cfg_t;

  typedef struct packed {
    logic done;          // one-cycle pulse at end of a received request
    logic [7:0] addr;
    logic addr_err;
    logic parity_err;
    logic framing_err;
    logic xfer_err;      // overrun or other transmission fault
  } rps_req_t;

  typedef struct packed {
    logic data8;
    logic parity_en;
    logic parity_odd;
    logic two_stop;
    logic [15:0] baud_div;
  } rps_fmt_t;

  typedef enum logic [1:0] {ST_IDLE, ST_GRACE, ST_ALARM} rps_err_state_t;

endpackage : rps_pkg

// [hw/rps_fifo.sv]
// small synchronous fifo
module rps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("rps_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic push;
  logic pop;

  // handshakes and next fill level
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign count_nxt = count_r + (AW + 1)'(push) - (AW + 1)'(pop);
  assign out_data = mem[rd_ptr_r];

  // storage
  always_ff @(posedge sys_clk) begin
    if (ce && push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers, level and flags
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_nxt;
      in_ready <= count_nxt < (AW + 1)'(DEPTH);
      out_valid <= count_nxt != '0;
    end
  end

endmodule : rps_fifo

// [bench/rps_sup_properties.sv]
// checks on port 1 and the shared alarms
module rps_sup_properties (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic drive_running,
  input wire logic run_from_link,
  input wire logic freq_from_link,
  input wire logic [1:0] comm_error_data_clear,
  input wire rps_pkg::rps_cfg_t port1_cfg,
  input wire rps_pkg::rps_req_t port1_req,
  input wire rps_pkg::rps_fmt_t port1_fmt,
  input wire logic port1_execute,
  input wire logic port1_comm_alarm,
  input wire logic port1_tx_valid,
  input wire logic [7:0] port1_tx_data,
  input wire logic port1_tx_ready,
  input wire logic alarm_stop,
  input wire logic clear_freq_cmds,
  input wire logic clear_run_bits
);
  // ==========================================================
  // helper terms
  wire qual = ce & drive_running & run_from_link & freq_from_link;
  wire good1 = ce & port1_req.done & ~|port1_req[3:0];
  wire mb1 = port1_cfg.protocol_select == rps_pkg::PROTO_MODBUS;
  wire legal1 = mb1 && port1_cfg.station_address inside {[8'h01:8'hf7]};
  wire hit1 = port1_req.addr == port1_cfg.station_address || port1_req.addr == 8'h00;
  wire ldr1 = port1_cfg.protocol_select == rps_pkg::PROTO_LOADER;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_mb_held;
    (ce && mb1 && port1_cfg.parity_select == 2'h0) [*2];
  endsequence
  sequence s_ldr_held;
    (ce && ldr1) [*2];
  endsequence
  sequence s_alarm_rise;
    ce && $rose(port1_comm_alarm) && comm_error_data_clear == 2'h3;
  endsequence

  // ==========================================================
  // station address, errors and alarms
  a_exec_station: assert property (good1 && legal1 && hit1 |=> port1_execute)
    else $error("execute missing");
  a_bad_station: assert property (good1 && mb1 && !legal1 |=> !port1_execute)
    else $error("illegal station executed");
  a_alarm_now: assert property (qual && port1_req.done && port1_req.parity_err
    && port1_cfg.error_action == 2'h0 |=> port1_comm_alarm)
    else $error("alarm missing");
  a_alarm_qual: assert property ($rose(port1_comm_alarm) |-> $past(qual))
    else $error("unqualified alarm");
  a_keep_running: assert property (port1_cfg.error_action == 2'h3
    && $stable(port1_cfg.error_action) |-> !$rose(port1_comm_alarm))
    else $error("alarm under continue");
  a_stop_clear: assert property (s_alarm_rise |=> alarm_stop && clear_freq_cmds && clear_run_bits)
    else $error("stop or clear missing");
  a_clear_sel: assert property (clear_freq_cmds |-> $past(comm_error_data_clear[0]))
    else $error("unselected clear");
  // ==========================================================
  // character format and transmit hold
  a_fmt_modbus: assert property (s_mb_held |-> port1_fmt.two_stop && !port1_fmt.parity_en)
    else $error("modbus stop bits wrong");
  a_fmt_loader: assert property (s_ldr_held |-> port1_fmt.data8 && port1_fmt.parity_en
    && !port1_fmt.parity_odd && !port1_fmt.two_stop)
    else $error("loader format wrong");
  a_tx_hold: assert property (port1_tx_valid && !port1_tx_ready |=> port1_tx_valid
    && $stable(port1_tx_data))
    else $error("stalled byte lost");
endmodule : rps_sup_properties

bind rps_supervisor rps_sup_properties u_props (.sys_clk, .rstn, .ce, .drive_running,
  .run_from_link, .freq_from_link, .comm_error_data_clear, .port1_cfg, .port1_req, .port1_fmt,
  .port1_execute, .port1_comm_alarm, .port1_tx_valid, .port1_tx_data, .port1_tx_ready,
  .alarm_stop, .clear_freq_cmds, .clear_run_bits);

// [bench/rps_host.sv]
// transmitter model recording bytes in order
module rps_host (
  input wire logic sys_clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got_q[$];
  // ready unless stalled, one byte per edge
  assign tx_ready = !stall;
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) got_q.push_back(tx_data);
  end
endmodule : rps_host

// [bench/tb.sv]
// self-checking bench of the supervisor
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [5:0] p; logic [7:0] s; logic [7:0] a; logic e;} rps_row_t;
  logic sys_clk, rstn, ar, oalm, stall, rv1, rr1, tv1, tr1, ex1, ex2, al1, stp, cf, cr, seen;
  logic [2:0] qual;
  logic [1:0] dclr;
  logic [7:0] rd1, td1;
  rps_pkg::rps_cfg_t c1, c2;
  rps_pkg::rps_req_t q1, q2;
  rps_pkg::rps_fmt_t f1;
  int err_count, samples_checked;
  int rate[5] = '{2400, 4800, 9600, 19200, 38400};
  rps_row_t rows[12] = '{'{6'h00, 8'h05, 8'h05, 1}, '{6'h00, 8'h05, 8'h06, 0},
    '{6'h00, 8'h05, 8'h00, 1}, '{6'h00, 8'hf7, 8'hf7, 1}, '{6'h00, 8'hf8, 8'hf8, 0},
    '{6'h05, 8'h7f, 8'hff, 1}, '{6'h05, 8'h80, 8'h80, 0}, '{6'h02, 8'h1f, 8'h63, 1},
    '{6'h01, 8'hff, 8'hff, 1}, '{6'h03, 8'hff, 8'hff, 1}, '{6'h04, 8'h05, 8'h05, 0},
    '{6'h32, 8'h05, 8'h05, 0}};

  rps_supervisor #(.TICK_CYCLES(4)) dut (.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1),
    .drive_running(qual[2]), .run_from_link(qual[1]), .freq_from_link(qual[0]),
    .alarm_reset(ar), .option_comm_alarm(oalm), .option_bus_alarm(oalm),
    .unit_link_alarm(oalm), .comm_error_data_clear(dclr), .port1_cfg(c1), .port2_cfg(c2),
    .port1_req(q1), .port2_req(q2), .port1_resp_valid(rv1), .port1_resp_data(rd1),
    .port1_resp_ready(rr1), .port2_resp_valid(1'b0), .port2_resp_data(8'h00),
    .port2_resp_ready(), .port1_tx_valid(tv1), .port1_tx_data(td1), .port1_tx_ready(tr1),
    .port2_tx_valid(), .port2_tx_data(), .port2_tx_ready(1'b1), .port1_fmt(f1),
    .port2_fmt(), .port1_execute(ex1), .port2_execute(ex2), .port1_comm_alarm(al1),
    .port2_comm_alarm(), .alarm_stop(stp), .clear_freq_cmds(cf), .clear_run_bits(cr));
  rps_host host (.sys_clk(sys_clk), .tx_valid(tv1), .tx_data(td1), .tx_ready(tr1),
    .stall(stall));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // request pulse; returns at the taking edge
  task req(input logic [7:0] a, input logic e);
    @(posedge sys_clk);
    q1.done <= 1'b1;
    q1.addr <= a;
    q1.parity_err <= e;
    @(posedge sys_clk);
    q1.done <= 1'b0;
    q1.parity_err <= 1'b0;
  endtask : req
  task act(input logic [1:0] a);
    @(posedge sys_clk);
    c1.error_action <= a;
    ar <= 1'b1;
    @(posedge sys_clk);
    ar <= 1'b0;
    tick(2);
  endtask : act
  task push(input logic [7:0] b);
    @(posedge sys_clk);
    rv1 <= 1'b1;
    rd1 <= b;
    @(negedge sys_clk);
    for (int i = 0; i < 200 && !rr1; i++) @(negedge sys_clk);
    @(posedge sys_clk);
    rv1 <= 1'b0;
  endtask : push
  task print_verdict;
    $display("mismatches %0d comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #(6000 * 5);
    err_count++;
    print_verdict();
  end

  // table rows, then hand-written cases
  initial begin
    {rstn, ar, oalm, stall, rv1, rd1, qual, q1, q2} = '0;
    dclr = 2'h3;
    c1 = '0;
    c1.station_address = 8'h05;
    c1.error_timer = 10'h001;
    c2 = c1;
    c2.protocol_select = 6'h32;
    c2.station_address = 8'h0a;
    c2.error_action = 2'h3;
    tick(3);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      @(posedge sys_clk);
      c1.protocol_select <= rows[i].p;
      c1.station_address <= rows[i].s;
      req(rows[i].a, 1'b0);
      #1;
      chk(ex1, rows[i].e);
    end
    for (int i = 1; i < 5; i++) begin
      @(posedge sys_clk);
      c1.baud_select <= 3'(i);
      tick(3);
      chk(f1.baud_div, 32'(200000000 / rate[i]));
    end
    @(posedge sys_clk);
    q2.done <= 1'b1;
    q2.addr <= 8'h0a;
    @(posedge sys_clk);
    q2.done <= 1'b0;
    #1;
    chk(ex2, 1);
    {c1.protocol_select, c1.station_address, qual} <= {6'h00, 8'h05, 3'b101};
    req(8'h05, 1'b1);
    tick(3);
    chk(al1, 0);
    qual <= 3'b111;
    req(8'h05, 1'b1);
    tick(1);
    chk(al1, 1);
    chk({stp, cf, cr}, 3'h7);
    act(2'h1);
    chk(al1, 0);
    req(8'h05, 1'b1);
    tick(20);
    chk(al1, 0);
    tick(40);
    chk(al1, 1);
    act(2'h2);
    req(8'h05, 1'b1);
    tick(10);
    req(8'h05, 1'b0);
    tick(60);
    chk(al1, 0);
    act(2'h3);
    req(8'h05, 1'b1);
    tick(60);
    chk(al1, 0);
    act(2'h0);
    req(8'h05, 1'b0);
    c1.no_response_time <= 6'h01;
    tick(300);
    chk(al1, 0);
    tick(150);
    chk(al1, 1);
    c1.no_response_time <= 6'h00;
    act(2'h3);
    {c1.response_interval, stall, qual} <= {7'h05, 1'b1, 3'b000};
    req(8'h05, 1'b0);
    for (int i = 0; i < 4; i++) push(8'h10 + 8'(i));
    tick(1);
    chk({tv1, rr1}, 2'h0);
    tick(30);
    chk(tv1, 1);
    stall <= 1'b0;
    push(8'h14);
    push(8'h15);
    tick(20);
    chk(host.got_q.size(), 6);
    foreach (host.got_q[i]) chk(host.got_q[i], 8'h10 + 8'(i));
    chk(tv1, 0);
    dclr <= 2'h1;
    oalm <= 1'b1;
    seen = 1'b0;
    repeat (3) begin
      tick(1);
      seen = seen | cf;
      chk(cr, 0);
    end
    chk(seen, 1);
    rstn <= 1'b0;
    tick(1);
    chk({al1, stp, tv1, ex1, rr1}, 5'h01);
    print_verdict();
  end
endmodule : tb
